// file: aac_cksum.sv
/*
  aac_cksum.sv: running write checksum, xor-accumulated over written bytes.
  assumes wr_en is a one-cycle strobe from the register port on the same clock.
*/
`timescale 1ns/1ps
`include "aac_regs.svh"
module aac_cksum (
  input  wire logic             ref_clk, // clock
  input  wire logic             nrst,    // async reset, low
  input  wire logic             ce,      // clock enable
  input  wire logic             wr_en,   // any register write
  input  wire logic             is_self, // write targets the checksum
  input  wire aac_pkg::aac_byte_t wdata, // write data
  output aac_pkg::aac_byte_t    sum_r    // checksum value
);
  wire aac_pkg::aac_byte_t sum_nxt = is_self ? wdata : (sum_r ^ wdata); // [R7] [R11]
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      sum_r <= `AAC_RST_CHECKSUM;
    else if (ce && wr_en)
      sum_r <= sum_nxt; // [R8]
endmodule : aac_cksum

// file: aac_host.sv
/*
  aac_host.sv: host model issuing register writes and reads on the control port.
  assumes the bank samples strobes on rising ref_clk and answers reads one edge later.
*/
`timescale 1ns/1ps
module aac_host (
  input  wire logic               ref_clk, // clock
  output logic                    wr_en,   // write strobe
  output logic                    rd_en,   // read strobe
  output aac_pkg::aac_byte_t      addr,    // address
  output aac_pkg::aac_byte_t      wdata,   // write data
  input  wire aac_pkg::aac_byte_t rdata    // read data
);
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr  = 8'h00;
    wdata = 8'h00;
  end
  // the trailing delay lets the taking edge land before the caller looks
  task automatic wr(input aac_pkg::aac_byte_t a, input aac_pkg::aac_byte_t d);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input aac_pkg::aac_byte_t a, output aac_pkg::aac_byte_t d);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    #1;
    d = rdata;
  endtask : rd
endmodule : aac_host

// file: aac_pkg.sv
/*
  aac_pkg.sv: types shared by the register bank files.
  assumes nothing beyond a SystemVerilog compiler.
*/
package aac_pkg;
  typedef logic [7:0] aac_byte_t;
  typedef logic [9:0] aac_conv_t;
  typedef enum logic [1:0] {AAC_POS_FIRST, AAC_POS_SECOND, AAC_POS_THIRD, AAC_POS_FOURTH} aac_pos_t;
endpackage : aac_pkg

// file: aac_regs.svh
/*
  aac_regs.svh: offsets, field positions and reset values of the page-zero tail registers.
  assumes it is included by bare name; definitions only.
*/
`ifndef AAC_REGS_SVH
`define AAC_REGS_SVH
`define AAC_OFF_CLK_CFG      8'h44
`define AAC_OFF_OFFSET_CFG   8'h45
`define AAC_OFF_BUS_CFG      8'h46
`define AAC_OFF_CONV_HIGH    8'h49
`define AAC_OFF_CONV_LOW     8'h4a
`define AAC_OFF_IDENTITY     8'h7d
`define AAC_OFF_CHECKSUM     8'h7e
`define AAC_OFF_BOOK         8'h7f
`define AAC_RST_CLK_CFG      8'h00
`define AAC_RST_OFFSET_CFG   8'h01
`define AAC_RST_BUS_CFG      8'hfc
`define AAC_RST_CHECKSUM     8'h00
`define AAC_RST_BOOK         8'h00
`define AAC_CLK_WMASK        8'hf1
`define AAC_BUS_WMASK        8'h7f
`define AAC_BUS_RO_SET       8'h80
`define AAC_CLK_DRIVE_BIT    0
`define AAC_RX_OFF_HI        4
`define AAC_RX_OFF_LO        0
`define AAC_TX_OFF_HI        7
`define AAC_TX_OFF_LO        5
`define AAC_POS_HI           1
`define AAC_POS_LO           0
`define AAC_CONV_HI          9
`define AAC_CONV_MID         2
`define AAC_CONV_LSB_HI      1
`define AAC_LOW_PAD          6'h00
`define AAC_SYNC_STAGES      3
`endif

// file: aac_sync.sv
/*
  aac_sync.sv: three-flop synchroniser with agreement filter for a bus of slow inputs.
  assumes the input is quasi-static relative to ref_clk.
*/
`timescale 1ns/1ps
`include "aac_regs.svh"
module aac_sync #(
  parameter int W = 10
) (
  input  wire logic         ref_clk, // clock
  input  wire logic         nrst,    // async reset, low
  input  wire logic         ce,      // clock enable
  input  wire logic [W-1:0] d_in,    // asynchronous input
  output logic      [W-1:0] q_out    // filtered value
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  wire          agree = (s2_r == s3_r);
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      q_out <= '0;
    end
    else if (ce)
    begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree)
        q_out <= s3_r;
    end
endmodule : aac_sync

// file: aac_tail_regs.sv
/*
  aac_tail_regs.sv: page-zero tail register bank (secondary port config, supply
  conversion readback, identity, write checksum, book select).
  assumes a control-bus front end on ref_clk delivering address, data and one-cycle
  write strobes; the conversion result arrives asynchronously from the converter.
*/
`timescale 1ns/1ps
`include "aac_regs.svh"
// Behaviour
// [R1] clock drive bit: 0 receive, 1 generate
// [R2] five-bit receive slot offset, resets one
// [R3] two-bit shared bus position select
// [R4] conversion bits nine..two at high address
// [R5] conversion low bits in seven..six, zeros
// [R6] identity: revision high, generation low nibble
// [R7] checksum write loads written byte
// [R8] checksum updates on any other write
// [R9] book selector at last page-zero address
// [R10] eight-bit book selector, resets zero
// [R11] checksum update is xor of bytes
module aac_tail_regs #(
  parameter logic [3:0] SILICON_REVISION   = 4'h1, // arbitrary value
  parameter logic [3:0] PROCESS_GENERATION = 4'h2  // arbitrary value
) (
  input  wire logic                ref_clk,                 // 40 MHz clock
  input  wire logic                nrst,                    // async reset, low
  input  wire logic                ce,                      // clock enable
  input  wire logic                page_zero,               // page zero selected
  input  wire logic                wr_en,                   // write strobe
  input  wire logic                rd_en,                   // read strobe
  input  wire aac_pkg::aac_byte_t  addr,                    // register address
  input  wire aac_pkg::aac_byte_t  wdata,                   // write data
  output aac_pkg::aac_byte_t       rdata,                   // read data, registered
  input  wire aac_pkg::aac_conv_t  supply_conversion_result,// converter result, async
  output logic                     second_port_clock_drive, // 1: generate bit clock
  output logic [4:0]               receive_slot_offset,     // receive slot offset
  output logic [2:0]               transmit_slot_offset,    // transmit slot offset
  output aac_pkg::aac_pos_t        shared_bus_position,     // position on shared bus
  output aac_pkg::aac_byte_t       book_sel                 // selected book
);
  aac_pkg::aac_byte_t clk_cfg_r;
  aac_pkg::aac_byte_t off_cfg_r;
  aac_pkg::aac_byte_t bus_cfg_r;
  aac_pkg::aac_byte_t book_r;
  aac_pkg::aac_byte_t sum_val;
  aac_pkg::aac_conv_t conv_s;
  aac_pkg::aac_byte_t rdata_nxt;

  // the book selector is visible from every page zero so software can always escape
  wire p0          = page_zero && (book_r == `AAC_RST_BOOK);
  wire hit_clk     = p0 && (addr == `AAC_OFF_CLK_CFG);
  wire hit_off     = p0 && (addr == `AAC_OFF_OFFSET_CFG);
  wire hit_bus     = p0 && (addr == `AAC_OFF_BUS_CFG);
  wire hit_hi      = p0 && (addr == `AAC_OFF_CONV_HIGH);
  wire hit_lo      = p0 && (addr == `AAC_OFF_CONV_LOW);
  wire hit_id      = p0 && (addr == `AAC_OFF_IDENTITY);
  wire hit_sum     = page_zero && (addr == `AAC_OFF_CHECKSUM);
  wire hit_book    = page_zero && (addr == `AAC_OFF_BOOK); // [R9]

  // the agree filter costs a cycle but keeps a torn multi-bit sample off the bus
  aac_sync #(
    .W($bits(aac_pkg::aac_conv_t))
  ) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .d_in    (supply_conversion_result),
    .q_out   (conv_s)
  );

  // every write, on any book or page, feeds the checksum
  aac_cksum u_cksum (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .wr_en   (wr_en),
    .is_self (hit_sum),
    .wdata   (wdata),
    .sum_r   (sum_val)
  );

  // named strobes keep every register process down to a single enable
  wire wr_take = ce && wr_en;
  wire rd_take = ce && rd_en;
  wire wr_clk  = wr_take && hit_clk;
  wire wr_off  = wr_take && hit_off;
  wire wr_bus  = wr_take && hit_bus;
  wire wr_book = wr_take && hit_book;
  wire aac_pkg::aac_byte_t clk_cfg_nxt = wdata & `AAC_CLK_WMASK; // [R1]
  wire aac_pkg::aac_byte_t bus_cfg_nxt = (wdata & `AAC_BUS_WMASK) | `AAC_BUS_RO_SET; // [R3]

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      clk_cfg_r <= `AAC_RST_CLK_CFG;
    else if (wr_clk)
      clk_cfg_r <= clk_cfg_nxt; // [R1]

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      off_cfg_r <= `AAC_RST_OFFSET_CFG;
    else if (wr_off)
      off_cfg_r <= wdata; // [R2]

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      bus_cfg_r <= `AAC_RST_BUS_CFG;
    else if (wr_bus)
      bus_cfg_r <= bus_cfg_nxt; // [R3]

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      book_r <= `AAC_RST_BOOK;
    else if (wr_book)
      book_r <= wdata; // [R10]

  wire aac_pkg::aac_byte_t conv_hi = conv_s[`AAC_CONV_HI:`AAC_CONV_MID]; // [R4]
  wire aac_pkg::aac_byte_t conv_lo = {conv_s[`AAC_CONV_LSB_HI:0], `AAC_LOW_PAD}; // [R5]
  wire aac_pkg::aac_byte_t ident   = {SILICON_REVISION, PROCESS_GENERATION}; // [R6]

  // priority order is harmless: the hits decode distinct addresses
  assign rdata_nxt = hit_clk  ? clk_cfg_r :
                     hit_off  ? off_cfg_r :
                     hit_bus  ? bus_cfg_r :
                     hit_hi   ? conv_hi   :
                     hit_lo   ? conv_lo   :
                     hit_id   ? ident     :
                     hit_sum  ? sum_val   :
                     hit_book ? book_r    :
                                8'h00;

  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst)
      rdata <= 8'h00;
    else if (rd_take)
      rdata <= rdata_nxt;

  assign second_port_clock_drive = clk_cfg_r[`AAC_CLK_DRIVE_BIT]; // [R1]
  assign receive_slot_offset     = off_cfg_r[`AAC_RX_OFF_HI:`AAC_RX_OFF_LO]; // [R2]
  assign transmit_slot_offset    = off_cfg_r[`AAC_TX_OFF_HI:`AAC_TX_OFF_LO];
  assign shared_bus_position     = aac_pkg::aac_pos_t'(bus_cfg_r[`AAC_POS_HI:`AAC_POS_LO]); // [R3]
  assign book_sel                = book_r; // [R10]

  // assertions
  sum_load_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
    (ce && wr_en && hit_sum) |=> (sum_val == $past(wdata)))
    else $error("checksum write did not load byte");
  sum_xor_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R8]
    (ce && wr_en && !hit_sum) |=> (sum_val == ($past(sum_val) ^ $past(wdata))))
    else $error("checksum not accumulated");
  sum_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R11]
    !(ce && wr_en) |=> $stable(sum_val))
    else $error("checksum changed without write");
  book_wr_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (ce && wr_en && page_zero && addr == `AAC_OFF_BOOK) |=> (book_sel == $past(wdata)))
    else $error("book write lost");
  book_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R10]
    !(ce && wr_en && hit_book) |=> $stable(book_sel))
    else $error("book changed unexpectedly");
  drive_bit_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    (ce && wr_en && hit_clk) |=> (second_port_clock_drive == $past(wdata[`AAC_CLK_DRIVE_BIT])))
    else $error("clock drive bit wrong");
  rx_off_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    (ce && wr_en && hit_off) |=> (receive_slot_offset == $past(wdata[`AAC_RX_OFF_HI:`AAC_RX_OFF_LO])))
    else $error("receive offset wrong");
  pos_sel_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    (ce && wr_en && hit_bus) |=> (shared_bus_position == $past(wdata[`AAC_POS_HI:`AAC_POS_LO])))
    else $error("bus position wrong");
  conv_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
    (ce && rd_en && hit_hi) |=> (rdata == $past(conv_s[`AAC_CONV_HI:`AAC_CONV_MID])))
    else $error("conversion high byte wrong");
  low_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R5]
    (ce && rd_en && hit_lo) |=> (rdata[5:0] == 6'h00 && rdata[7:6] == $past(conv_s[1:0])))
    else $error("conversion low byte wrong");
  id_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R6]
    (ce && rd_en && hit_id) |=> (rdata == {SILICON_REVISION, PROCESS_GENERATION}))
    else $error("identity byte wrong");

  // register fields and masks
  clk_rsvd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    (clk_cfg_r & ~`AAC_CLK_WMASK) == 8'h00)
    else $error("clock config reserved bits set");
  clk_wr_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    wr_clk
    |=> (((clk_cfg_r ^ $past(wdata)) & `AAC_CLK_WMASK) == 8'h00))
    else $error("clock config write lost");
  clk_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    !wr_clk
    |=> $stable(clk_cfg_r))
    else $error("clock config changed without write");
  drive_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    !wr_clk
    |=> $stable(second_port_clock_drive))
    else $error("clock drive changed without write");
  off_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    !wr_off
    |=> $stable(off_cfg_r))
    else $error("offset config changed without write");
  rx_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    !wr_off
    |=> $stable(receive_slot_offset))
    else $error("receive offset changed without write");
  tx_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    !wr_off
    |=> $stable(transmit_slot_offset))
    else $error("transmit offset changed without write");
  tx_off_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    wr_off
    |=> (transmit_slot_offset == $past(wdata[`AAC_TX_OFF_HI:`AAC_TX_OFF_LO])))
    else $error("transmit offset wrong");
  bus_ro_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    (bus_cfg_r & `AAC_BUS_RO_SET) == `AAC_BUS_RO_SET)
    else $error("bus config top bit cleared");
  bus_wr_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    wr_bus
    |=> (((bus_cfg_r ^ $past(wdata)) & `AAC_BUS_WMASK) == 8'h00))
    else $error("bus config write lost");
  bus_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    !wr_bus
    |=> $stable(bus_cfg_r))
    else $error("bus config changed without write");
  pos_keep_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    !wr_bus
    |=> $stable(shared_bus_position))
    else $error("bus position changed without write");

  // read path
  clk_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R1]
    (rd_take && hit_clk)
    |=> (rdata[`AAC_CLK_DRIVE_BIT] == $past(second_port_clock_drive)))
    else $error("clock drive readback wrong");
  off_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R2]
    (rd_take && hit_off)
    |=> (rdata == {$past(transmit_slot_offset), $past(receive_slot_offset)}))
    else $error("offset readback wrong");
  bus_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R3]
    (rd_take && hit_bus)
    |=> (rdata[`AAC_POS_HI:`AAC_POS_LO] == $past(shared_bus_position)))
    else $error("bus position readback wrong");
  rd_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
    !rd_take
    |=> $stable(rdata))
    else $error("read data changed without read");
  book_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (rd_take && page_zero && (addr == `AAC_OFF_BOOK))
    |=> (rdata == $past(book_sel)))
    else $error("book readback wrong");
  sum_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
    (rd_take && page_zero && (addr == `AAC_OFF_CHECKSUM))
    |=> (rdata == $past(sum_val)))
    else $error("checksum readback wrong");
  rd_nomap_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (rd_take && page_zero && (addr > `AAC_OFF_CONV_LOW) && (addr < `AAC_OFF_IDENTITY))
    |=> (rdata == 8'h00))
    else $error("unmapped read not zero");
  far_book_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (rd_take && page_zero && (book_r != `AAC_RST_BOOK) && (addr == `AAC_OFF_CLK_CFG))
    |=> (rdata == 8'h00))
    else $error("config visible outside book zero");
  page_off_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (rd_take && !page_zero)
    |=> (rdata == 8'h00))
    else $error("read outside page zero not zero");

  // checksum and paging
  sum_book_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R7]
    (wr_take && page_zero && (book_r != `AAC_RST_BOOK) && (addr == `AAC_OFF_CHECKSUM))
    |=> (sum_val == $past(wdata)))
    else $error("checksum load lost outside book zero");
  sum_page_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R8]
    (wr_take && !page_zero)
    |=> (sum_val == ($past(sum_val) ^ $past(wdata))))
    else $error("checksum missed write on other page");
  sum_far_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R8]
    (wr_take && !page_zero && (addr == `AAC_OFF_CHECKSUM))
    |=> (sum_val == ($past(sum_val) ^ $past(wdata))))
    else $error("checksum loaded from other page");
  sum_offbook_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R8]
    (wr_take && (book_r != `AAC_RST_BOOK) && (addr != `AAC_OFF_CHECKSUM))
    |=> (sum_val == ($past(sum_val) ^ $past(wdata))))
    else $error("checksum missed write on other book");
  sum_ro_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R8]
    (wr_take && hit_hi)
    |=> (sum_val == ($past(sum_val) ^ $past(wdata))))
    else $error("checksum missed read-only write");
  book_any_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (wr_take && page_zero && (book_r != `AAC_RST_BOOK) && (addr == `AAC_OFF_BOOK))
    |=> (book_sel == $past(wdata)))
    else $error("book write lost outside book zero");
  book_page_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (wr_take && !page_zero)
    |=> $stable(book_sel))
    else $error("book written from other page");
  cfg_offbook_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R9]
    (wr_take && (book_r != `AAC_RST_BOOK))
    |=> ($stable(clk_cfg_r) && $stable(off_cfg_r) && $stable(bus_cfg_r)))
    else $error("config written outside book zero");
  ce_freeze_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R10]
    !ce
    |=> ($stable(rdata) && $stable(book_sel) && $stable(sum_val) && $stable(clk_cfg_r)))
    else $error("state moved with clock enable low");

  // conversion synchroniser
  sync_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
    !ce
    |=> $stable(conv_s))
    else $error("conversion moved with clock enable low");
  sync_agree_a: assert property (@(posedge ref_clk) disable iff (!nrst) // [R4]
    !$stable(conv_s)
    |-> (conv_s == $past(u_sync.s3_r)))
    else $error("conversion took unfiltered value");
  cov_sum_c: cover property (@(posedge ref_clk) disable iff (!nrst) ce && wr_en && hit_sum);
  cov_book_c: cover property (@(posedge ref_clk) disable iff (!nrst) ce && wr_en && hit_book && wdata == 8'hff);
  cov_conv_c: cover property (@(posedge ref_clk) disable iff (!nrst) ce && rd_en && hit_lo);
  cov_drive_c: cover property (@(posedge ref_clk) disable iff (!nrst) second_port_clock_drive);
  cov_page_c: cover property (@(posedge ref_clk) disable iff (!nrst) wr_take && !page_zero);
endmodule : aac_tail_regs

// file: tb_audio_amp_control_page_tail_regs.sv
/*
  tb_audio_amp_control_page_tail_regs.sv: self-checking bench for the tail register bank.
  assumes the host model drives the control port; the bench drives reset, ce, page, converter.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_audio_amp_control_page_tail_regs;
  logic               ref_clk   = 1'b0;
  logic               nrst      = 1'b0;
  logic               ce        = 1'b1;
  logic               page_zero = 1'b1;
  logic               wr_en, rd_en, drive;
  logic [4:0]         rx;
  logic [2:0]         tx;
  aac_pkg::aac_pos_t  pos;
  aac_pkg::aac_byte_t addr, wdata, rdata, book_sel, rv;
  aac_pkg::aac_byte_t ck        = 8'h00;
  aac_pkg::aac_conv_t conv      = 10'h000;
  int                 n_fail    = 0;
  int                 compares  = 0;
  int                 cyc       = 0;
  always #12.5 ref_clk = ~ref_clk;
  aac_host i_host (.ref_clk(ref_clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata));
  aac_tail_regs i_dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .page_zero(page_zero), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata), .supply_conversion_result(conv),
    .second_port_clock_drive(drive), .receive_slot_offset(rx), .transmit_slot_offset(tx),
    .shared_bus_position(pos), .book_sel(book_sel));
  task automatic summarize;
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  // expected checksum follows every taken write
  task automatic w(input aac_pkg::aac_byte_t a, input aac_pkg::aac_byte_t d);
    i_host.wr(a, d);
    if (ce)
      ck = (a == 8'h7e && page_zero) ? d : ck ^ d;
  endtask : w
  task automatic r(input aac_pkg::aac_byte_t a, input aac_pkg::aac_byte_t e);
    i_host.rd(a, rv);
    `CHK(rv, e)
  endtask : r
  task automatic t_reset;
    `CHK(drive, 1'b0)
    `CHK(rx, 5'h01)
    `CHK(tx, 3'h0)
    `CHK(pos, aac_pkg::AAC_POS_FIRST)
    `CHK(book_sel, 8'h00)
    r(8'h44, 8'h00);
    r(8'h45, 8'h01);
    r(8'h46, 8'hfc);
    r(8'h7d, 8'h12);
    r(8'h7e, 8'h00);
    r(8'h7f, 8'h00);
    r(8'h50, 8'h00);
  endtask : t_reset
  task automatic t_port;
    w(8'h44, 8'hff);
    `CHK(drive, 1'b1)
    r(8'h44, 8'hf1);
    w(8'h44, 8'h00);
    `CHK(drive, 1'b0)
    w(8'h45, 8'h3f);
    `CHK(rx, 5'h1f)
    `CHK(tx, 3'h1)
    for (int i = 0; i < 4; i++)
    begin
      w(8'h46, 8'(i));
      `CHK(pos, aac_pkg::aac_pos_t'(i))
      r(8'h46, 8'h80 | 8'(i));
    end
  endtask : t_port
  task automatic t_conv;
    @(posedge ref_clk);
    conv <= 10'h3a5;
    repeat (8) @(posedge ref_clk);
    r(8'h49, 8'he9);
    r(8'h4a, 8'h40);
    @(posedge ref_clk);
    conv <= 10'h05a;
    repeat (8) @(posedge ref_clk);
    r(8'h49, 8'h16);
    r(8'h4a, 8'h80);
  endtask : t_conv
  task automatic t_cksum;
    w(8'h7e, 8'h5a);
    r(8'h7e, 8'h5a);
    w(8'h49, 8'h33);
    r(8'h49, 8'h16);
    @(posedge ref_clk);
    page_zero <= 1'b0;
    w(8'h7e, 8'h0f);
    r(8'h7e, 8'h00);
    @(posedge ref_clk);
    page_zero <= 1'b1;
    r(8'h7e, ck);
    w(8'h7f, 8'h03);
    w(8'h44, 8'hff);
    `CHK(drive, 1'b0)
    r(8'h44, 8'h00);
    r(8'h7e, ck);
    w(8'h7e, 8'ha5);
    r(8'h7e, 8'ha5);
    w(8'h7f, 8'h00);
    // ce low must freeze both the book and the checksum
    @(posedge ref_clk);
    ce <= 1'b0;
    w(8'h7f, 8'h55);
    @(posedge ref_clk);
    ce <= 1'b1;
    `CHK(book_sel, 8'h00)
    r(8'h7e, ck);
  endtask : t_cksum
  task automatic t_book;
    w(8'h7f, 8'hff);
    `CHK(book_sel, 8'hff)
    r(8'h7f, 8'hff);
    w(8'h7f, 8'h00);
    `CHK(book_sel, 8'h00)
  endtask : t_book
  initial
  begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    #1;
    t_reset();
    t_port();
    t_conv();
    t_cksum();
    t_book();
    summarize();
  end
endmodule : tb_audio_amp_control_page_tail_regs
